// ### inc/eei_pkg.sv
// eei_pkg: constants and types of the ethernet error injector
package eei_pkg;
  // one second of the 25 MHz clock
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned SEC_CYC = SEC_NS / CLK_NS;
  localparam logic [3:0] TEN_LAST = 4'h9;
  // lanes and skew history depth
  localparam int NL = 4;
  localparam int HD = 64;
  localparam int SKW = 6;
  localparam int DW = 32;
  localparam int CW = 16;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BURST = 8'h04;
  localparam logic [7:0] A_TRIG = 8'h08;
  localparam logic [7:0] A_LANE = 8'h0c;
  localparam logic [7:0] A_SKEW = 8'h10;
  localparam logic [7:0] A_FREQ = 8'h14;
  localparam logic [7:0] A_NFRM = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  // control, trigger and status word fields
  localparam int F_MODE = 0;
  localparam int F_ALARM = 4;
  localparam int F_TGT = 8;
  localparam int F_EXP = 12;
  localparam int F_R1G = 16;
  localparam int F_FEC = 17;
  localparam int F_GO = 0;
  localparam int F_BUSY = 0;
  localparam int F_CNT = 16;
  // corruption patterns
  localparam logic [31:0] FLIP = 32'h0000_0001;
  localparam logic [31:0] FEC_FLIP = 32'h0000_03ff;
  localparam logic [1:0] SH_BAD = 2'h0;
  typedef enum logic [2:0] {
    M_OFF = 3'h0, M_MAN = 3'h1, M_SEC = 3'h2, M_SEC10 = 3'h3,
    M_RATIO = 3'h4, M_PBURST = 3'h5, M_ALT = 3'h6, M_ALL = 3'h7
  } eei_mode_t;
  typedef enum logic [3:0] {
    T_FCS = 4'h0, T_PRE = 4'h1, T_IPC = 4'h2, T_L4C = 4'h3,
    T_PAT = 4'h4, T_SEQ = 4'h5, T_SYM = 4'h6, T_FEC = 4'h7,
    T_PCS = 4'h8
  } eei_tgt_t;
  typedef enum logic [1:0] {S_IDLE = 2'h1, S_BURST = 2'h2} eei_st_t;
  // blocks per burst for exponent 2..7; lower codes clamp to 2
  function automatic logic [23:0] eei_pow10(input logic [2:0] k);
    case (k)
      3'h3: eei_pow10 = 24'h0003e8;
      3'h4: eei_pow10 = 24'h002710;
      3'h5: eei_pow10 = 24'h0186a0;
      3'h6: eei_pow10 = 24'h0f4240;
      3'h7: eei_pow10 = 24'h989680;
      default: eei_pow10 = 24'h000064;
    endcase
  endfunction : eei_pow10
endpackage : eei_pkg

// ### src/eei_injector.sv
// eei_injector: error, alarm, skew and rate offset injection
`timescale 1ns/10ps
`default_nettype none
// How it works
// - mode off injects no errors and aborts any running burst; alarm, skew and trim still apply
// - alarm select drives the alarm output continuously, no burst control
// - manual mode: each trigger injects exactly one burst then stops
// - one-second mode: a burst starts every second without trigger
// - ten-second mode: a burst starts every tenth second tick
// - ratio mode: one burst per 10^k blocks, trigger ignored
// - fcs target flips a bit in the fcs word
// - preamble target flips a bit of the preamble word
// - ip checksum target flips a bit of the ipv4 checksum word
// - layer-4 target flips a bit of the tcp or udp checksum word
// - pattern target flips a bit in the payload test pattern
// - sequence target flips a bit of the sequence number word
// - symbol target at 10g forces an invalid sync header
// - symbol target at 1g or below raises the mii error signal
// - fec target with fec enabled corrupts one coded symbol
// - pcs burst mode injects the configured count once per trigger, then stops
// - alternate mode starts a burst once per configured frame count
// - all mode starts a burst at every frame start
// - pcs errors hit only lanes selected in the lane mask
// - selected lanes are delayed by the skew count in bit times
// - skew count zero passes every lane with no delay
// - signed deviation drives the rate trim, positive is faster
module eei_injector #(
  parameter int unsigned SEC_CYCLES = eei_pkg::SEC_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  input wire logic [31:0] inData,
  input wire logic inValid,
  input wire logic inSof,
  input wire logic inEof,
  input wire logic [3:0] inTag,
  input wire logic [1:0] inSync,
  input wire logic [3:0] laneIn,
  output logic [31:0] outData,
  output logic outValid,
  output logic outSof,
  output logic outEof,
  output logic [1:0] outSync,
  output logic txEr,
  output logic alarmOut,
  output logic [3:0] laneOut,
  output logic signed [15:0] freqTrim
);

  typedef struct packed {
    eei_pkg::eei_mode_t mode;
    logic alarm;
    eei_pkg::eei_tgt_t tgt;
    logic [2:0] expo;
    logic rate1g;
    logic fecEn;
    logic [15:0] blen;
    logic [3:0] lmask;
    logic [5:0] skew;
    logic [15:0] freq;
    logic [15:0] nfrm;
    eei_pkg::eei_st_t st;
    logic [15:0] rem;
    logic [15:0] injCnt;
    logic [31:0] secCnt;
    logic [3:0] tenCnt;
    logic [23:0] blkCnt;
    logic [15:0] frmCnt;
    logic [63:0][3:0] hist;
    logic [31:0] oData;
    logic oValid;
    logic oSof;
    logic oEof;
    logic [1:0] oSync;
    logic oEr;
    logic oAlarm;
    logic [3:0] oLane;
    logic [15:0] oFreq;
    logic [31:0] rdData;
  } eei_state_t;

  eei_state_t r;
  eei_state_t next_r;
  logic trig;
  logic secTick;
  logic ratTick;
  logic frmTick;
  logic hit;
  logic start;
  logic [3:0] laneSk;
  logic [3:0] laneErr;

  // frame field targets hit their tagged word, others any valid word
  function automatic logic isUnit(input eei_pkg::eei_tgt_t t,
                                  input logic [3:0] tag);
    isUnit = (t == eei_pkg::T_SYM) || (t == eei_pkg::T_FEC) ||
             (t == eei_pkg::T_PCS) || (tag == t);
  endfunction : isUnit

  ////////////////////////////////////////////////////////////////////
  assign trig = wrStb && addr == eei_pkg::A_TRIG && wrData[eei_pkg::F_GO];
  assign secTick = r.secCnt == SEC_CYCLES - 1;
  // >= keeps the count sane when the exponent shrinks mid-run
  assign ratTick = inValid &&
    r.blkCnt >= eei_pkg::eei_pow10(r.expo) - 24'h1;
  assign frmTick = inValid && inSof && r.frmCnt >= r.nfrm - 16'h1;
  assign hit = r.st == eei_pkg::S_BURST && r.mode != eei_pkg::M_OFF &&
    inValid && isUnit(r.tgt, inTag);

  for (genvar i = 0; i < eei_pkg::NL; i++) begin : g_lane
    assign laneSk[i] = (r.lmask[i] && r.skew != '0) ?
      r.hist[r.skew - 6'h1][i] : laneIn[i];
    assign laneErr[i] = hit && r.tgt == eei_pkg::T_PCS && r.lmask[i];
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    start = 1'b0;
    // free running second timer; block counter advances on valid input, frame counter on valid frame start
    next_r.secCnt = secTick ? '0 : r.secCnt + 32'h1;
    if (secTick) begin
      next_r.tenCnt = (r.tenCnt == eei_pkg::TEN_LAST) ? 4'h0 :
        r.tenCnt + 4'h1;
    end
    if (inValid) begin
      next_r.blkCnt = ratTick ? '0 : r.blkCnt + 24'h1;
    end
    if (inValid && inSof) begin
      next_r.frmCnt = frmTick ? '0 : r.frmCnt + 16'h1;
    end
    // burst start source per mode
    unique case (r.mode)
      eei_pkg::M_OFF: start = 1'b0;
      eei_pkg::M_MAN: start = trig;
      eei_pkg::M_PBURST: start = trig;
      eei_pkg::M_SEC: start = secTick;
      eei_pkg::M_SEC10: start = secTick && r.tenCnt == eei_pkg::TEN_LAST;
      eei_pkg::M_RATIO: start = ratTick;
      eei_pkg::M_ALT: start = frmTick;
      eei_pkg::M_ALL: start = inValid && inSof;
    endcase
    // starts while busy are dropped so a new start never cuts a burst short; only mode off aborts it
    unique case (r.st)
      eei_pkg::S_IDLE: begin
        if (start && r.blen != '0) begin
          next_r.st = eei_pkg::S_BURST;
          next_r.rem = r.blen;
        end
      end
      eei_pkg::S_BURST: begin
        if (hit) begin
          next_r.rem = r.rem - 16'h1;
          if (r.rem == 16'h1) begin
            next_r.st = eei_pkg::S_IDLE;
            next_r.injCnt = r.injCnt + 16'h1;
          end
        end
      end
      default: next_r.st = eei_pkg::S_IDLE;
    endcase
    if (r.mode == eei_pkg::M_OFF) begin
      next_r.st = eei_pkg::S_IDLE;
    end
    // stream path, one cycle of latency for every signal
    next_r.oData = inData;
    next_r.oValid = inValid;
    next_r.oSof = inSof;
    next_r.oEof = inEof;
    next_r.oSync = inSync;
    next_r.oEr = 1'b0;
    if (hit) begin
      unique case (r.tgt)
        eei_pkg::T_FCS: next_r.oData = inData ^ eei_pkg::FLIP;
        eei_pkg::T_PRE: next_r.oData = inData ^ eei_pkg::FLIP;
        eei_pkg::T_IPC: next_r.oData = inData ^ eei_pkg::FLIP;
        eei_pkg::T_L4C: next_r.oData = inData ^ eei_pkg::FLIP;
        eei_pkg::T_PAT: next_r.oData = inData ^ eei_pkg::FLIP;
        eei_pkg::T_SEQ: next_r.oData = inData ^ eei_pkg::FLIP;
        eei_pkg::T_SYM: begin
          if (r.rate1g) begin
            next_r.oEr = 1'b1;
          end else begin
            next_r.oSync = eei_pkg::SH_BAD;
          end
        end
        eei_pkg::T_FEC: begin
          if (r.fecEn) begin
            next_r.oData = inData ^ eei_pkg::FEC_FLIP;
          end
        end
        eei_pkg::T_PCS: next_r.oData = inData;
        default: next_r.oData = inData;
      endcase
    end
    next_r.hist = {r.hist[eei_pkg::HD-2:0], laneIn};
    next_r.oLane = laneSk ^ laneErr;
    next_r.oAlarm = r.alarm;
    next_r.oFreq = r.freq;
    // register writes
    if (wrStb) begin
      unique case (addr)
        eei_pkg::A_CTRL: begin
          next_r.mode = eei_pkg::eei_mode_t'(wrData[eei_pkg::F_MODE +: 3]);
          next_r.alarm = wrData[eei_pkg::F_ALARM];
          next_r.tgt = eei_pkg::eei_tgt_t'(wrData[eei_pkg::F_TGT +: 4]);
          next_r.expo = wrData[eei_pkg::F_EXP +: 3];
          next_r.rate1g = wrData[eei_pkg::F_R1G];
          next_r.fecEn = wrData[eei_pkg::F_FEC];
        end
        eei_pkg::A_BURST: next_r.blen = wrData[eei_pkg::CW-1:0];
        eei_pkg::A_LANE: next_r.lmask = wrData[eei_pkg::NL-1:0];
        eei_pkg::A_SKEW: next_r.skew = wrData[eei_pkg::SKW-1:0];
        eei_pkg::A_FREQ: next_r.freq = wrData[eei_pkg::CW-1:0];
        eei_pkg::A_NFRM: next_r.nfrm = wrData[eei_pkg::CW-1:0];
        default: next_r.blen = r.blen;
      endcase
    end
    // read data stand for one cycle only
    next_r.rdData = '0;
    if (rdStb) begin
      unique case (addr)
        eei_pkg::A_CTRL: begin
          next_r.rdData[eei_pkg::F_MODE +: 3] = r.mode;
          next_r.rdData[eei_pkg::F_ALARM] = r.alarm;
          next_r.rdData[eei_pkg::F_TGT +: 4] = r.tgt;
          next_r.rdData[eei_pkg::F_EXP +: 3] = r.expo;
          next_r.rdData[eei_pkg::F_R1G] = r.rate1g;
          next_r.rdData[eei_pkg::F_FEC] = r.fecEn;
        end
        eei_pkg::A_BURST: next_r.rdData[eei_pkg::CW-1:0] = r.blen;
        eei_pkg::A_TRIG: next_r.rdData[eei_pkg::CW-1:0] = r.rem;
        eei_pkg::A_LANE: next_r.rdData[eei_pkg::NL-1:0] = r.lmask;
        eei_pkg::A_SKEW: next_r.rdData[eei_pkg::SKW-1:0] = r.skew;
        eei_pkg::A_FREQ: next_r.rdData[eei_pkg::CW-1:0] = r.freq;
        eei_pkg::A_NFRM: next_r.rdData[eei_pkg::CW-1:0] = r.nfrm;
        eei_pkg::A_STAT: begin
          next_r.rdData[eei_pkg::F_BUSY] = r.st == eei_pkg::S_BURST;
          next_r.rdData[eei_pkg::F_CNT +: 16] = r.injCnt;
        end
        default: next_r.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.st <= eei_pkg::S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign rdData = r.rdData;
  assign outData = r.oData;
  assign outValid = r.oValid;
  assign outSof = r.oSof;
  assign outEof = r.oEof;
  assign outSync = r.oSync;
  assign txEr = r.oEr;
  assign alarmOut = r.oAlarm;
  assign laneOut = r.oLane;
  assign freqTrim = r.oFreq;

  ////////////////////////////////////////////////////////////////////
  a_off_clean: assert property (
    @(posedge clk) disable iff (reset)
    r.mode == eei_pkg::M_OFF |=> outData == $past(inData) && !txEr)
    else $error("error injected while mode off");

  a_alarm_level: assert property (
    @(posedge clk) disable iff (reset)
    r.alarm && !wrStb |=> alarmOut ##1 alarmOut)
    else $error("alarm not held");

  a_burst_load: assert property (
    @(posedge clk) disable iff (reset)
    r.st == eei_pkg::S_IDLE && start && r.blen != '0 &&
    r.mode != eei_pkg::M_OFF |=> r.rem == $past(r.blen))
    else $error("burst length not sampled");

  a_burst_stop: assert property (
    @(posedge clk) disable iff (reset)
    hit && r.rem == 16'h1 |=> r.st == eei_pkg::S_IDLE)
    else $error("burst ran past its count");

  a_sec_start: assert property (
    @(posedge clk) disable iff (reset)
    r.mode == eei_pkg::M_SEC && !wrStb && secTick &&
    r.st == eei_pkg::S_IDLE && r.blen != '0 |=> r.st == eei_pkg::S_BURST)
    else $error("second burst missed");

  a_ten_wait: assert property (
    @(posedge clk) disable iff (reset)
    r.mode == eei_pkg::M_SEC10 && r.st == eei_pkg::S_IDLE &&
    r.tenCnt != eei_pkg::TEN_LAST |=> r.st == eei_pkg::S_IDLE)
    else $error("ten second burst too early");

  a_ratio_trig: assert property (
    @(posedge clk) disable iff (reset)
    r.mode == eei_pkg::M_RATIO && r.st == eei_pkg::S_IDLE && !ratTick
    |=> r.st == eei_pkg::S_IDLE)
    else $error("ratio burst without block count");

  a_fcs_flip: assert property (
    @(posedge clk) disable iff (reset)
    hit && r.tgt == eei_pkg::T_FCS |=> outData != $past(inData))
    else $error("fcs not corrupted");

  a_sym_mii: assert property (
    @(posedge clk) disable iff (reset)
    hit && r.tgt == eei_pkg::T_SYM && r.rate1g |=> txEr)
    else $error("mii error not raised");

  // back-to-back hits keep the pulse high, so check the idle side apart
  a_mii_idle: assert property (
    @(posedge clk) disable iff (reset)
    !(hit && r.tgt == eei_pkg::T_SYM && r.rate1g) |=> !txEr)
    else $error("mii error without a hit");

  a_lane_mask: assert property (
    @(posedge clk) disable iff (reset)
    !r.lmask[0] |=> laneOut[0] == $past(laneIn[0]))
    else $error("unselected lane touched");

  a_lane_hit: assert property (
    @(posedge clk) disable iff (reset)
    hit && r.tgt == eei_pkg::T_PCS && r.lmask[0] |=>
    laneOut[0] != $past(laneSk[0]))
    else $error("selected lane not errored");

  a_zero_skew: assert property (
    @(posedge clk) disable iff (reset)
    r.skew == '0 && !hit |=> laneOut == $past(laneIn))
    else $error("skew inserted at zero");

  a_stream_pass: assert property (
    @(posedge clk) disable iff (reset)
    1'b1 |=> outValid == $past(inValid) && outSof == $past(inSof) &&
    outEof == $past(inEof))
    else $error("frame markers altered");

endmodule : eei_injector
`default_nettype wire

// ### testbench/eei_net_model.sv
// eei_net_model: far-end receiver that tallies corrupted traffic
`timescale 1ns/10ps
`default_nettype none
module eei_net_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] outData,
  input wire logic outValid,
  input wire logic [1:0] outSync,
  input wire logic txEr,
  output int hitCnt,
  output int erCnt,
  output int syncCnt,
  output logic [31:0] lastHit
);
  ////////////////////////////////////////////////////////////////////////
  // the generator sends all-zero words, so any set bit is an injected hit
  // receiver tallies
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hitCnt <= 0;
      erCnt <= 0;
      syncCnt <= 0;
      lastHit <= 32'h0;
    end else begin
      if (outValid && outData != 32'h0) begin
        hitCnt <= hitCnt + 1;
        lastHit <= outData;
      end
      if (txEr) erCnt <= erCnt + 1;
      if (outValid && outSync == 2'h0) syncCnt <= syncCnt + 1;
    end
  end
endmodule : eei_net_model
`default_nettype wire

// ### testbench/tb_top.sv
// tb_top: register and stream tests of the error injector
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wrData = 32'h0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [31:0] rdData;
  logic inValid = 1'b0;
  logic inSof = 1'b0;
  logic [3:0] inTag = 4'h0;
  logic [3:0] laneIn = 4'h0;
  logic [31:0] outData;
  logic outValid;
  logic [1:0] outSync;
  logic txEr;
  logic alarmOut;
  logic [3:0] laneOut;
  logic signed [15:0] freqTrim;
  logic [3:0] hist [0:7];
  int hitCnt, erCnt, syncCnt, badCount, checks, h0, e0, s0;
  logic [31:0] lastHit, rv;
  always #20 clk = ~clk;
  eei_injector #(.SEC_CYCLES(50)) eei_injector_inst (
    .clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .inData(32'h0),
    .inValid(inValid), .inSof(inSof), .inEof(1'b0), .inTag(inTag),
    .inSync(2'h1), .laneIn(laneIn), .outData(outData),
    .outValid(outValid), .outSof(), .outEof(), .outSync(outSync),
    .txEr(txEr), .alarmOut(alarmOut), .laneOut(laneOut),
    .freqTrim(freqTrim)
  );
  eei_net_model eei_net_model_inst (
    .clk(clk), .reset(reset), .outData(outData), .outValid(outValid),
    .outSync(outSync), .txEr(txEr), .hitCnt(hitCnt), .erCnt(erCnt),
    .syncCnt(syncCnt), .lastHit(lastHit)
  );
  // johnson lane pattern, period 8, so delays of 1 and 4 differ
  always @(posedge clk) begin
    laneIn <= {laneIn[2:0], ~laneIn[3]};
    hist[0] <= laneIn;
    for (int i = 1; i < 8; i++) hist[i] <= hist[i - 1];
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      badCount++;
    end
  endtask : chk
  task automatic rng(string nm, int lo, int hi, int v);
    chk(nm, 32'h1, {31'h0, v >= lo && v <= hi});
  endtask : rng
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask : rd
  // n back-to-back words in frames of f words, all tagged t
  task automatic send(int n, logic [3:0] t, int f);
    h0 = hitCnt;
    e0 = erCnt;
    s0 = syncCnt;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      inValid <= 1'b1;
      inTag <= t;
      inSof <= (f != 0) && (i % f == 0);
    end
    @(posedge clk);
    inValid <= 1'b0;
    inSof <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : send
  task automatic setup(logic [31:0] ctl, logic [15:0] n, bit trig);
    // mode off first drops a burst left pending by the last test
    wr(eei_pkg::A_CTRL, 32'h0);
    wr(eei_pkg::A_CTRL, ctl);
    wr(eei_pkg::A_BURST, {16'h0, n});
    if (trig) wr(eei_pkg::A_TRIG, 32'h1);
  endtask : setup
  task automatic lanes(logic [5:0] s);
    wr(eei_pkg::A_SKEW, {26'h0, s});
    repeat (12) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1 chk("lane0", {31'h0, hist[(s == 0) ? 0 : s][0]}, laneOut[0]);
      chk("lane3", {31'h0, hist[0][3]}, laneOut[3]);
    end
  endtask : lanes
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    badCount++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(eei_pkg::A_STAT, rv);
    chk("status", 32'h0, rv);
    wr(8'h20, 32'hffff);
    rd(8'h20, rv);
    chk("unmapped", 32'h0, rv);
    setup(32'h0, 16'h2, 1);
    send(20, 4'h0, 0);
    chk("off", 32'h0, 32'(hitCnt - h0));
    $display("test reset and off done");
    // hits for each frame field target; ..
    for (int t = 0; t < 6; t++) begin
      setup(32'h1 | (t << 8), 16'h2, 1);
      send(6, 4'(t), 0);
      chk("manual hits", 32'h2, 32'(hitCnt - h0));
    end
    setup(32'h1, 16'h3, 1);
    wr(eei_pkg::A_BURST, 32'h1);
    send(6, 4'h0, 0);
    chk("burst sampled", 32'h3, 32'(hitCnt - h0));
    setup(32'h5, 16'h3, 1);
    send(8, 4'h0, 0);
    chk("pcs burst", 32'h3, 32'(hitCnt - h0));
    $display("test manual done");
    setup(32'h1_0601, 16'h2, 1);
    send(5, 4'hf, 0);
    chk("tx error", 32'h2, 32'(erCnt - e0));
    setup(32'h0601, 16'h2, 1);
    send(5, 4'hf, 0);
    chk("bad sync", 32'h2, 32'(syncCnt - s0));
    setup(32'h2_0701, 16'h1, 1);
    send(3, 4'hf, 0);
    chk("fec", eei_pkg::FEC_FLIP, lastHit);
    $display("test symbol done");
    setup(32'h0402, 16'h1, 0);
    send(300, 4'h4, 0);
    rng("one second", 5, 7, hitCnt - h0);
    setup(32'h0403, 16'h1, 0);
    send(1100, 4'h4, 0);
    rng("ten second", 2, 3, hitCnt - h0);
    setup(32'h2404, 16'h1, 1);
    send(1050, 4'h4, 0);
    rng("ratio", 10, 11, hitCnt - h0);
    setup(32'h7, 16'h1, 0);
    send(12, 4'h0, 4);
    chk("all frames", 32'h3, 32'(hitCnt - h0));
    wr(eei_pkg::A_NFRM, 32'h2);
    setup(32'h6, 16'h1, 0);
    send(16, 4'h0, 4);
    chk("alternate", 32'h2, 32'(hitCnt - h0));
    $display("test periodic done");
    wr(eei_pkg::A_CTRL, 32'h10);
    repeat (30) @(posedge clk);
    #1 chk("alarm", 32'h1, {31'h0, alarmOut});
    wr(eei_pkg::A_LANE, 32'h1);
    lanes(6'h3);
    lanes(6'h0);
    setup(32'h0801, 16'h1, 1);
    send(3, 4'hf, 0);
    chk("pcs data", 32'h0, 32'(hitCnt - h0));
    rd(eei_pkg::A_STAT, rv);
    chk("pcs done", 32'h0, {31'h0, rv[eei_pkg::F_BUSY]});
    wr(eei_pkg::A_FREQ, 32'hfff0);
    repeat (2) @(posedge clk);
    chk("freq", 32'hfff0, {16'h0, freqTrim});
    $display("test lanes and rate done");
    final_report;
  end
endmodule : tb_top
`default_nettype wire
